// ### shared/pfm_map.svh
// Purpose: offsets, field positions and reset values of the pin mux
// Assumes: AHB-Lite byte addresses, one 32-bit word per register
// Notes: included by the pin mux design
`ifndef PFM_MAP_SVH
`define PFM_MAP_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define PFM_SYSCTL_OFS 8'h00
`define PFM_STATUS_OFS 8'h04
`define PFM_SP2_SEL_BIT 10
`define PFM_SYSCTL_RST 32'h0000_0400
`define PFM_STAT_STRAP_LSB 0
`define PFM_STAT_HOST_BIT 4
`define PFM_STAT_SEL_BIT 8

// ----------------------------------------------------------------
// Strap positions (A, B, C, D) and reset values
// ----------------------------------------------------------------
`define PFM_STRAP_HOST_BIT 2
`define PFM_SP2_SEL_RST 1'h1
`define PFM_STRAP_RST 4'h0

`endif

// ### shared/pfm_pkg.sv
// Purpose: carrier types of the pin mux
// Assumes: nothing beyond the map header
// Notes: pin groups travel as packed structs
package pfm_pkg;

  // ----------------------------------------------------------------
  // Shared pins, one field per pin group
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [13:1] addr;
    logic [7:0] data;
    logic sp2_tx_data_or_flag_out;
    logic sp2_tx_sync_or_irq_one;
    logic sp2_rx_sync_or_irq_zero;
    logic sp2_rx_data_or_flag_in;
    logic [3:0] combo;
  } pfm_pins_t;

  // Host port strobes seen by the core
  typedef struct packed {
    logic [15:0] host_addr_data_bus;
    logic host_port_select_n;
    logic host_read_strobe_n;
    logic host_write_strobe_n;
    logic host_address_latch;
  } pfm_host_in_t;

endpackage : pfm_pkg

// ### hdl/pfm_pin_mux.sv
// Purpose: shared pin function multiplexer with mode straps
// Assumes: ref_clk 250 MHz, rst synchronous active high, AHB-Lite slave
// Notes: combo bit 0 is edge_interrupt_n with prog_flag_four
//
// Register access over AHB-Lite and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`include "pfm_map.svh"
module pfm_pin_mux (
  input wire logic ref_clk,
  input wire logic rst,
  // AHB-Lite
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Pins
  input wire pfm_pkg::pfm_pins_t pin_i,
  output pfm_pkg::pfm_pins_t pin_o,
  output pfm_pkg::pfm_pins_t pin_oe,
  input wire logic [3:0] strap_pin_i,
  // Core, memory interface
  input wire logic [13:1] mem_addr,
  input wire logic mem_addr_oe,
  input wire logic [7:0] mem_wdata,
  input wire logic mem_data_oe,
  output logic [7:0] mem_rdata,
  // Core, host port
  input wire logic [15:0] host_rdata,
  input wire logic host_rdata_oe,
  input wire logic host_acknowledge_n,
  output pfm_pkg::pfm_host_in_t host_in,
  // Core, second serial port and flags
  input wire logic sp2_tx_data,
  input wire logic sp2_tx_sync_o,
  input wire logic sp2_tx_sync_oe,
  input wire logic sp2_rx_sync_o,
  input wire logic sp2_rx_sync_oe,
  input wire logic flag_out,
  output logic sp2_tx_sync_i,
  output logic sp2_rx_sync_i,
  output logic sp2_rx_data,
  output logic irq_one_n,
  output logic irq_zero_n,
  output logic flag_in,
  // Core, combined interrupt and flag pins
  input wire logic [3:0] pf_hi_o,
  input wire logic [3:0] pf_hi_oe,
  output logic [3:0] irq_combo_n,
  output logic [3:0] pf_hi_in,
  // State
  output logic [3:0] mode_straps,
  output logic host_mode,
  output logic serial_port_two_select
);
  import pfm_pkg::*;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  // Bitwise: take the new level only where stages two and three agree
  function automatic logic [32:0] agree(input logic [32:0] s2,
                                        input logic [32:0] s3,
                                        input logic [32:0] held);
    agree = (s2 & ~(s2 ^ s3)) | (held & (s2 ^ s3));
  endfunction : agree

  // No reset on the chain so straps are already settled at release
  logic [32:0] sync1_r;
  logic [32:0] sync2_r;
  logic [32:0] sync3_r;
  logic [32:0] filt_r;
  pfm_pins_t pin_f;
  logic [3:0] strap_f;

  always_ff @(posedge ref_clk)
  begin
    sync1_r <= {pin_i, strap_pin_i};
    sync2_r <= sync1_r;
    sync3_r <= sync2_r;
    filt_r <= agree(sync2_r, sync3_r, filt_r);
  end

  assign pin_f = filt_r[32:4];
  assign strap_f = filt_r[3:0];

  // ----------------------------------------------------------------
  // Mode straps
  // ----------------------------------------------------------------
  logic rst_d_r;
  logic [3:0] straps_r;

  always_ff @(posedge ref_clk)
    rst_d_r <= rst;

  // Caught by the clock at the release edge, not by the reset itself
  always_ff @(posedge ref_clk)
  begin
    if (rst_d_r && !rst)
      straps_r <= strap_f;
  end

  assign mode_straps = straps_r;
  assign host_mode = straps_r[`PFM_STRAP_HOST_BIT];

  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------
  logic wr_pend_r;
  logic [7:0] wr_addr_r;
  logic sel_r;
  logic sel_nxt;
  logic [31:0] hrdata_r;
  logic addr_ok;

  function automatic logic [31:0] read_word(input logic [7:0] a,
                                            input logic sel,
                                            input logic [3:0] st);
    read_word = 32'h0000_0000;
    if (a == `PFM_SYSCTL_OFS)
      read_word[`PFM_SP2_SEL_BIT] = sel;
    else if (a == `PFM_STATUS_OFS)
    begin
      read_word[`PFM_STAT_STRAP_LSB +: 4] = st;
      read_word[`PFM_STAT_HOST_BIT] = st[`PFM_STRAP_HOST_BIT];
      read_word[`PFM_STAT_SEL_BIT] = sel;
    end
  endfunction : read_word

  assign addr_ok = hsel && htrans[1] && hready;
  assign hreadyout = 1'h1;
  assign hresp = 1'h0;
  assign hrdata = hrdata_r;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      wr_pend_r <= 1'h0;
      wr_addr_r <= 8'h00;
    end
    else
    begin
      wr_pend_r <= addr_ok && hwrite;
      wr_addr_r <= haddr[7:0];
    end
  end

  // Forward a write in its data phase to a read in the same cycle
  always_comb
  begin
    sel_nxt = sel_r;
    if (wr_pend_r && wr_addr_r == `PFM_SYSCTL_OFS)
      sel_nxt = hwdata[`PFM_SP2_SEL_BIT];
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      sel_r <= `PFM_SP2_SEL_RST;
    else
      sel_r <= sel_nxt;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      hrdata_r <= 32'h0000_0000;
    else if (addr_ok && !hwrite)
      hrdata_r <= read_word(haddr[7:0], sel_nxt, straps_r);
  end

  assign serial_port_two_select = sel_r;

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  pfm_pins_t po_nxt;
  pfm_pins_t oe_nxt;
  pfm_pins_t pin_o_r;
  pfm_pins_t pin_oe_r;

  always_comb
  begin
    po_nxt = '0;
    oe_nxt = '0;
    if (host_mode)
    begin
      // Host owns address pins and D2..D0; D3 acknowledges
      po_nxt.addr = host_rdata[12:0];
      oe_nxt.addr = {13{host_rdata_oe}};
      po_nxt.data[2:0] = host_rdata[15:13];
      oe_nxt.data[2:0] = {3{host_rdata_oe}};
      po_nxt.data[3] = host_acknowledge_n;
      oe_nxt.data[3] = 1'h1;
    end
    else
    begin
      po_nxt.addr = mem_addr;
      oe_nxt.addr = {13{mem_addr_oe}};
      po_nxt.data = mem_wdata;
      oe_nxt.data = {8{mem_data_oe}};
    end
    if (sel_r)
    begin
      po_nxt.sp2_tx_data_or_flag_out = sp2_tx_data;
      oe_nxt.sp2_tx_data_or_flag_out = 1'h1;
      po_nxt.sp2_tx_sync_or_irq_one = sp2_tx_sync_o;
      oe_nxt.sp2_tx_sync_or_irq_one = sp2_tx_sync_oe;
      po_nxt.sp2_rx_sync_or_irq_zero = sp2_rx_sync_o;
      oe_nxt.sp2_rx_sync_or_irq_zero = sp2_rx_sync_oe;
    end
    else
    begin
      po_nxt.sp2_tx_data_or_flag_out = flag_out;
      oe_nxt.sp2_tx_data_or_flag_out = 1'h1;
    end
    po_nxt.combo = pf_hi_o;
    oe_nxt.combo = pf_hi_oe;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      pin_o_r <= '0;
      pin_oe_r <= '0;
    end
    else
    begin
      pin_o_r <= po_nxt;
      pin_oe_r <= oe_nxt;
    end
  end

  assign pin_o = pin_o_r;
  assign pin_oe = pin_oe_r;

  // ----------------------------------------------------------------
  // Pin levels to the core
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      mem_rdata <= 8'h00;
      host_in <= {16'h0000, 1'h1, 1'h1, 1'h1, 1'h0};
    end
    else if (host_mode)
    begin
      mem_rdata <= 8'h00;
      host_in <= {pin_f.data[2:0], pin_f.addr, pin_f.data[4],
                  pin_f.data[6], pin_f.data[7], pin_f.data[5]};
    end
    else
    begin
      mem_rdata <= pin_f.data;
      host_in <= {16'h0000, 1'h1, 1'h1, 1'h1, 1'h0};
    end
  end

  // Unselected functions sit at their idle levels
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      {sp2_tx_sync_i, sp2_rx_sync_i, sp2_rx_data} <= 3'h0;
      {irq_one_n, irq_zero_n, flag_in} <= 3'h6;
    end
    else if (sel_r)
    begin
      sp2_tx_sync_i <= pin_f.sp2_tx_sync_or_irq_one;
      sp2_rx_sync_i <= pin_f.sp2_rx_sync_or_irq_zero;
      sp2_rx_data <= pin_f.sp2_rx_data_or_flag_in;
      {irq_one_n, irq_zero_n, flag_in} <= 3'h6;
    end
    else
    begin
      {sp2_tx_sync_i, sp2_rx_sync_i, sp2_rx_data} <= 3'h0;
      irq_one_n <= pin_f.sp2_tx_sync_or_irq_one;
      irq_zero_n <= pin_f.sp2_rx_sync_or_irq_zero;
      flag_in <= pin_f.sp2_rx_data_or_flag_in;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      irq_combo_n <= 4'hf;
      pf_hi_in <= 4'h0;
    end
    else
    begin
      irq_combo_n <= pin_f.combo;
      pf_hi_in <= pin_f.combo;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_host_addr_route: assert property (
    @(posedge ref_clk) disable iff (rst)
    host_mode && $stable(host_mode) |=>
      host_in.host_addr_data_bus == $past({pin_f.data[2:0], pin_f.addr}))
    else $error("host bus not routed from shared pins");

  a_host_ack_drive: assert property (
    @(posedge ref_clk) disable iff (rst)
    host_mode |=> pin_oe.data[3] && pin_o.data[3] == $past(host_acknowledge_n))
    else $error("acknowledge not driven in host mode");

  a_combo_both: assert property (
    @(posedge ref_clk) disable iff (rst)
    1'h1 |=> irq_combo_n == $past(pin_f.combo) && pf_hi_in == irq_combo_n)
    else $error("combined pin lost a function");

  a_strap_capture: assert property (
    @(posedge ref_clk) disable iff (rst)
    $fell(rst) |=> mode_straps == $past(strap_f))
    else $error("strap not captured at reset release");

  a_sp2_serial: assert property (
    @(posedge ref_clk) disable iff (rst)
    sel_r |=> pin_o.sp2_tx_data_or_flag_out == $past(sp2_tx_data))
    else $error("serial transmit data not on shared pin");

  a_sp2_irq: assert property (
    @(posedge ref_clk) disable iff (rst)
    !sel_r |=> pin_o.sp2_tx_data_or_flag_out == $past(flag_out) &&
      irq_one_n == $past(pin_f.sp2_tx_sync_or_irq_one))
    else $error("flag or interrupt not on shared pin");

  a_sel_reset: assert property (
    @(posedge ref_clk) disable iff (rst)
    $past(rst) |-> serial_port_two_select)
    else $error("serial select not set after reset");

  a_strap_hold: assert property (
    @(posedge ref_clk) disable iff (rst)
    !$past(rst) && !$past(rst, 2) |-> $stable(mode_straps))
    else $error("straps changed during operation");

endmodule : pfm_pin_mux

// ### test/pfm_board.sv
// Purpose: board devices sitting on the shared pins
// Assumes: no pull resistors on any shared pin
// Notes: an undriven pin shows the inverse of its last level
`timescale 1ns/100ps
module pfm_board
  import pfm_pkg::*;
(
  input wire logic ref_clk,
  input wire pfm_pkg::pfm_pins_t pin_o,
  input wire pfm_pkg::pfm_pins_t pin_oe,
  input wire pfm_pkg::pfm_pins_t brd_val,
  input wire pfm_pkg::pfm_pins_t brd_en,
  output pfm_pkg::pfm_pins_t pin_i
);
  pfm_pins_t held_r = '0;
  pfm_pins_t drv;

  // Released pins flip to the inverse of their last driven level
  assign drv = pfm_pins_t'(pin_oe | brd_en);

  // Off the rising edge, so the design sees settled levels
  always_ff @(negedge ref_clk)
  begin
    held_r <= pfm_pins_t'((drv & pin_i) | (~drv & held_r));
  end

  assign pin_i = pfm_pins_t'((pin_oe & pin_o) | (~pin_oe & brd_en & brd_val)
    | (~pin_oe & ~brd_en & ~held_r));
endmodule : pfm_board

// ### test/tb_pin_function_mux.sv
// Purpose: self-checking bench of the pin mux
// Assumes: zero-wait AHB-Lite slave, pin path of five edges
// Notes: expectations queued by the driver, checked at falling edges
`timescale 1ns/100ps
module tb_pin_function_mux;
  import pfm_pkg::*;
  logic ref_clk, rst, hsel, hwrite, hreadyout, hresp;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd_val, e;
  pfm_pins_t pin_i, pin_o, pin_oe, brd_val, brd_en;
  logic [3:0] strap_pin_i, pf_hi_o, pf_hi_oe, irq_combo_n, pf_hi_in;
  logic [3:0] mode_straps;
  logic [13:1] mem_addr;
  logic [7:0] mem_wdata, mem_rdata;
  logic [15:0] host_rdata;
  logic mem_addr_oe, mem_data_oe, host_rdata_oe, host_acknowledge_n;
  logic sp2_tx_data, sp2_tx_sync_o, sp2_tx_sync_oe, sp2_rx_sync_o;
  logic sp2_rx_sync_oe, flag_out, sp2_tx_sync_i, sp2_rx_sync_i;
  logic sp2_rx_data, irq_one_n, irq_zero_n, flag_in, host_mode;
  logic serial_port_two_select;
  pfm_host_in_t host_in;
  int seed = 94;
  int miscompares = 0;
  int n_compared = 0;
  int k;
  int id_q[$];
  logic [31:0] exp_q[$];
  string names[7] = '{"hrdata", "mode_straps", "host_in", "sp2_pins",
    "combo_in", "mem_rdata", "host_pins"};

  pfm_pin_mux DUT (.ref_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .pin_i,
    .pin_o, .pin_oe, .strap_pin_i, .mem_addr, .mem_addr_oe, .mem_wdata,
    .mem_data_oe, .mem_rdata, .host_rdata, .host_rdata_oe,
    .host_acknowledge_n, .host_in, .sp2_tx_data, .sp2_tx_sync_o,
    .sp2_tx_sync_oe, .sp2_rx_sync_o, .sp2_rx_sync_oe, .flag_out,
    .sp2_tx_sync_i, .sp2_rx_sync_i, .sp2_rx_data, .irq_one_n, .irq_zero_n,
    .flag_in, .pf_hi_o, .pf_hi_oe, .irq_combo_n, .pf_hi_in, .mode_straps,
    .host_mode, .serial_port_two_select);

  pfm_board board (.ref_clk, .pin_o, .pin_oe, .brd_val, .brd_en, .pin_i);

  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  function automatic logic [31:0] seen(input int id);
    case (id)
      0: seen = rd_val;
      1: seen = {28'h0, mode_straps};
      2: seen = {12'h0, host_in};
      3: seen = {25'h0, pin_o.sp2_tx_data_or_flag_out, irq_one_n, irq_zero_n,
        flag_in, sp2_tx_sync_i, sp2_rx_sync_i, sp2_rx_data};
      4: seen = {24'h0, irq_combo_n, pf_hi_in};
      6: seen = {4'h0, pin_oe.addr, pin_o.addr, pin_oe.data[3],
        pin_o.data[3]};
      default: seen = {24'h0, mem_rdata};
    endcase
  endfunction : seen

  task automatic compare(input string s, input logic [31:0] x,
    input logic [31:0] g);
    n_compared++;
    if (g !== x)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", s, x, g);
    end
  endtask : compare

  task automatic cmp_reg(input logic [31:0] x);
    compare(names[0], x, seen(0));
  endtask : cmp_reg

  task automatic cmp_straps(input logic [31:0] x);
    compare(names[1], x, seen(1));
  endtask : cmp_straps

  task automatic cmp_host(input logic [31:0] x);
    compare(names[2], x, seen(2));
  endtask : cmp_host

  task automatic cmp_sp2(input logic [31:0] x);
    compare(names[3], x, seen(3));
  endtask : cmp_sp2

  task automatic cmp_combo(input logic [31:0] x);
    compare(names[4], x, seen(4));
  endtask : cmp_combo

  task automatic cmp_mem(input logic [31:0] x);
    compare(names[5], x, seen(5));
  endtask : cmp_mem

  task automatic cmp_drive(input logic [31:0] x);
    compare(names[6], x, seen(6));
  endtask : cmp_drive

  always @(negedge ref_clk)
  begin
    while (id_q.size() > 0)
    begin
      k = id_q.pop_front();
      e = exp_q.pop_front();
      case (k)
        0: cmp_reg(e);
        1: cmp_straps(e);
        2: cmp_host(e);
        3: cmp_sp2(e);
        4: cmp_combo(e);
        6: cmp_drive(e);
        default: cmp_mem(e);
      endcase
    end
  end

  task automatic results();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : results

  task automatic note(input int id, input logic [31:0] x);
    id_q.push_back(id);
    exp_q.push_back(x);
  endtask : note

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cyc

  // Entered just after a rising edge; waits are bounded
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge ref_clk); while (hreadyout !== 1'b1 && ++n < 50);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'b1 && ++n < 50);
    rd_val = hrdata;
    if (n >= 50)
    begin
      miscompares++;
      results();
    end
  endtask : ahb

  task automatic rd(input logic [31:0] a, input logic [31:0] x);
    ahb(1'b0, a, 32'h0);
    note(0, x);
  endtask : rd

  task automatic regs(input logic [3:0] st);
    rd(32'h0, 32'h0000_0400);
    rd(32'h4, {23'h0, 1'h1, 3'h0, st[2], st});
    $display("test reset straps %h done", st);
  endtask : regs

  task automatic pins(input logic s);
    logic [2:0] v;
    logic [3:0] c;
    v = 3'($random(seed));
    c = 4'($random(seed));
    brd_en.sp2_tx_sync_or_irq_one <= 1'h1;
    brd_en.sp2_rx_sync_or_irq_zero <= 1'h1;
    brd_en.sp2_rx_data_or_flag_in <= 1'h1;
    brd_en.combo <= 4'hf;
    brd_val.sp2_tx_sync_or_irq_one <= v[2];
    brd_val.sp2_rx_sync_or_irq_zero <= v[1];
    brd_val.sp2_rx_data_or_flag_in <= v[0];
    brd_val.combo <= c;
    sp2_tx_data <= v[0];
    flag_out <= ~v[0];
    cyc(8);
    note(3, s ? {25'h0, v[0], 3'h6, v} : {25'h0, ~v[0], v, 3'h0});
    note(4, {24'h0, c, c});
    $display("test pins select %h done", s);
  endtask : pins

  initial
  begin
    logic [12:0] a;
    logic [7:0] d;
    rst = 1'b1;
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    {brd_val, brd_en, pf_hi_o, pf_hi_oe, mem_addr, mem_wdata} = '0;
    {mem_addr_oe, mem_data_oe, host_rdata, host_rdata_oe} = '0;
    {host_acknowledge_n, sp2_tx_data, flag_out} = '0;
    {sp2_tx_sync_o, sp2_tx_sync_oe, sp2_rx_sync_o, sp2_rx_sync_oe} = '0;
    strap_pin_i = 4'h3;
    cyc(20);
    rst <= 1'b0;
    cyc(2);
    regs(4'h3);
    strap_pin_i <= 4'hc;
    cyc(8);
    note(1, 32'h3);
    note(2, 32'he);
    pins(1'b1);
    ahb(1'b1, 32'h0, 32'h0);
    rd(32'h0, 32'h0);
    ahb(1'b1, 32'h8, 32'hffff_ffff);
    rd(32'h8, 32'h0);
    ahb(1'b1, 32'h4, 32'hffff_ffff);
    rd(32'h4, 32'h3);
    $display("test register writes done");
    pins(1'b0);
    rst <= 1'b1;
    strap_pin_i <= 4'h4;
    cyc(20);
    rst <= 1'b0;
    cyc(2);
    regs(4'h4);
    a = 13'($random(seed));
    d = 8'($random(seed));
    brd_en.addr <= 13'h1fff;
    brd_en.data <= 8'hf7;
    brd_val.addr <= a;
    brd_val.data <= d;
    cyc(8);
    note(2, {12'h0, d[2:0], a, d[4], d[6], d[7], d[5]});
    note(5, 32'h0);
    $display("test host mode done");
    host_rdata <= 16'($random(seed));
    host_rdata_oe <= 1'b1;
    cyc(2);
    note(6, {4'h0, 13'h1fff, host_rdata[12:0], 1'h1, 1'h0});
    $display("test host drive done");
    pins(1'b1);
    cyc(2);
    results();
  end
endmodule : tb_pin_function_mux
